// ==== hdl/rx_dma_pkg.sv ====
// Constants shared by the receive DMA channel and its write engine.
// Assumes a single 125 MHz system clock domain.
package rx_dma_pkg;
    // =====================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h88;
    localparam logic [7:0] DEST_OFS = 8'h8C;
    localparam logic [7:0] LEN_OFS = 8'h90;
    localparam logic [7:0] PROG_OFS = 8'h94;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h98;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h9C;
    // =====================================================
    // Field positions and widths
    localparam int GO_BIT = 0;
    localparam int RELOAD_BIT = 1;
    localparam int SRC_BIT = 4;
    localparam int ADDR_W = 18;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [17:0] FIELD_RESET = 18'h0_0000;
    // Interrupt status bits: done, abort, error
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ABORT = 1;
    localparam int IRQ_ERR = 2;
    localparam int IRQ_W = 3;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Engine states, Gray along idle-fetch-write-done
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_FETCH = 2'h1,
        ST_WRITE = 2'h3,
        ST_DONE = 2'h2
    } eng_state_t;
endpackage

// ==== hdl/rx_dma_engine.sv ====
// Byte mover: pops the chosen receive FIFO, writes memory bytes.
// Assumes FIFO and memory ports are logic on the same clock.
`timescale 1ns/1ns
module rx_dma_engine
    import rx_dma_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic source_sel,
    input wire logic [rx_dma_pkg::ADDR_W-1:0] base_addr,
    input wire logic [rx_dma_pkg::ADDR_W-1:0] byte_length,
    output logic busy,
    output logic done,
    output logic error,
    output logic [rx_dma_pkg::ADDR_W-1:0] progress_count,
    // Receive FIFOs
    input wire logic fifo0_valid,
    input wire logic [7:0] fifo0_data,
    output logic fifo0_pop,
    input wire logic fifo1_valid,
    input wire logic [7:0] fifo1_data,
    output logic fifo1_pop,
    // Memory write port
    output logic mem_wr,
    output logic [rx_dma_pkg::ADDR_W-1:0] mem_addr,
    output logic [7:0] mem_data,
    input wire logic mem_ready,
    input wire logic mem_err
);
    import rx_dma_pkg::*;

    typedef struct packed
    {
        eng_state_t st;
        logic src;
        logic [ADDR_W-1:0] addr;
        logic [ADDR_W-1:0] len;
        logic [ADDR_W-1:0] cnt;
        logic [7:0] data;
        logic done;
        logic err;
        // Abort seen during a write, held until that write is answered
        logic halt;
    } eng_t;

    eng_t s_q;
    eng_t s_d;
    logic sel_valid;

    // =====================================================
    // Source mux
    assign sel_valid = s_q.src ? fifo1_valid : fifo0_valid;
    assign fifo0_pop = (s_q.st == ST_FETCH) && !s_q.src && fifo0_valid && !abort;
    assign fifo1_pop = (s_q.st == ST_FETCH) && s_q.src && fifo1_valid && !abort;

    // =====================================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        case (s_q.st)
            ST_IDLE:
            begin
                if (start)
                begin
                    // Parameters frozen here; later register writes wait for next start
                    s_d.src = source_sel;
                    s_d.addr = base_addr;
                    s_d.len = byte_length;
                    s_d.cnt = '0;
                    s_d.halt = 1'b0;
                    s_d.st = (byte_length == '0) ? ST_DONE : ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (abort)
                    s_d.st = ST_IDLE;
                else if (sel_valid)
                begin
                    s_d.data = s_q.src ? fifo1_data : fifo0_data;
                    s_d.st = ST_WRITE;
                end
            end
            ST_WRITE:
            begin
                // Abort waits out an issued write so memory never sees a torn cycle;
                // the one-cycle request is parked until the write is answered
                if (abort)
                    s_d.halt = 1'b1;
                if (mem_err)
                begin
                    s_d.err = 1'b1;
                    s_d.cnt = '0;
                    s_d.st = ST_IDLE;
                end
                else if (mem_ready)
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                    s_d.addr = s_q.addr + 1'b1;
                    if (abort || s_q.halt)
                        s_d.st = ST_IDLE;
                    else if (s_q.cnt + 1'b1 == s_q.len)
                        s_d.st = ST_DONE;
                    else
                        s_d.st = ST_FETCH;
                end
            end
            ST_DONE:
            begin
                s_d.done = 1'b1;
                s_d.cnt = '0;
                s_d.st = ST_IDLE;
            end
            default:
                s_d.st = ST_IDLE;
        endcase
    end

    // =====================================================
    // State register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign busy = (s_q.st != ST_IDLE);
    assign done = s_q.done;
    assign error = s_q.err;
    assign progress_count = s_q.cnt;
    assign mem_wr = (s_q.st == ST_WRITE);
    assign mem_addr = s_q.addr;
    assign mem_data = s_q.data;
endmodule

// ==== hdl/rx_dma_channel.sv ====
// Receive-side special DMA channel with AXI4-Lite register slave.
// Assumes FIFOs and memory run on aclk; synchronous active-low reset.
// Assumes software polls or takes the interrupt; one popped byte is held here until its write is answered.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module rx_dma_channel
    import rx_dma_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // First serial receive FIFO
    input wire logic first_serial_rx_fifo_valid,
    input wire logic [7:0] first_serial_rx_fifo_data,
    output logic first_serial_rx_fifo_pop,
    // Second serial receive FIFO
    input wire logic second_serial_rx_fifo_valid,
    input wire logic [7:0] second_serial_rx_fifo_data,
    output logic second_serial_rx_fifo_pop,
    // Memory write port
    output logic mem_wr,
    output logic [17:0] mem_addr,
    output logic [7:0] mem_data,
    input wire logic mem_ready,
    input wire logic mem_err,
    // Interrupt
    output logic irq
);
    import rx_dma_pkg::*;

    typedef struct packed
    {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic go;
        logic reload;
        logic source_select;
        logic [ADDR_W-1:0] dest_address;
        logic [ADDR_W-1:0] byte_length;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic start;
        logic abort;
    } regs_t;

    regs_t r_q;
    regs_t r_d;
    logic busy;
    logic eng_done;
    logic eng_err;
    logic [ADDR_W-1:0] progress_count;
    logic do_wr;
    logic do_rd;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    // Read mux result and its error flag
    logic [31:0] rd_word;
    logic rd_bad;

    // =====================================================
    // Write engine
    // Start and abort reach it as one-cycle pulses from the registers
    rx_dma_engine u_rx_dma_engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(r_q.start),
        .abort(r_q.abort),
        .source_sel(r_q.source_select),
        .base_addr(r_q.dest_address),
        .byte_length(r_q.byte_length),
        .busy(busy),
        .done(eng_done),
        .error(eng_err),
        .progress_count(progress_count),
        .fifo0_valid(first_serial_rx_fifo_valid),
        .fifo0_data(first_serial_rx_fifo_data),
        .fifo0_pop(first_serial_rx_fifo_pop),
        .fifo1_valid(second_serial_rx_fifo_valid),
        .fifo1_data(second_serial_rx_fifo_data),
        .fifo1_pop(second_serial_rx_fifo_pop),
        .mem_wr(mem_wr),
        .mem_addr(mem_addr),
        .mem_data(mem_data),
        .mem_ready(mem_ready),
        .mem_err(mem_err)
    );

    // =====================================================
    // Bus handshakes: address and data held separately, either order
    // Each ready drops while its word is held, so a second write simply
    // waits for the response to go; one master needs no queue
    assign s_axi_awready = !r_q.aw_held;
    assign s_axi_wready = !r_q.w_held;
    assign s_axi_bvalid = r_q.bvalid;
    assign s_axi_bresp = r_q.bresp;
    assign s_axi_arready = !r_q.rvalid;
    assign s_axi_rvalid = r_q.rvalid;
    assign s_axi_rdata = r_q.rdata;
    assign s_axi_rresp = r_q.rresp;
    assign do_wr = r_q.aw_held && r_q.w_held && !r_q.bvalid;
    // A new read is taken only once the last read data has gone
    assign do_rd = s_axi_arvalid && !r_q.rvalid;
    // Level interrupt, high while any enabled event is pending
    assign irq = |(r_q.irq_stat & r_q.irq_mask);

    // Byte-lane mask, one lane per write strobe
    for (genvar g = 0; g < 4; g++)
    begin : g_lane
        assign wmask[g*8 +: 8] = {8{r_q.w_strb[g]}};
    end

    // Control word as software reads it back; reserved bits stay zero
    always_comb
    begin
        ctrl_word = CTRL_RESET;
        ctrl_word[GO_BIT] = r_q.go;
        ctrl_word[RELOAD_BIT] = r_q.reload;
        ctrl_word[SRC_BIT] = r_q.source_select;
    end

    // =====================================================
    // Read data, decoded straight from the bus address
    always_comb
    begin
        rd_word = '0;
        rd_bad = 1'b0;
        case ({s_axi_araddr[7:2], 2'b00})
            CTRL_OFS: rd_word = ctrl_word;
            DEST_OFS: rd_word = {14'h0, r_q.dest_address};
            LEN_OFS: rd_word = {14'h0, r_q.byte_length};
            PROG_OFS: rd_word = {14'h0, progress_count};
            IRQ_STAT_OFS: rd_word = {29'h0, r_q.irq_stat};
            IRQ_MASK_OFS: rd_word = {29'h0, r_q.irq_mask};
            // Unmapped words read as zero and answer with an error
            default: rd_bad = 1'b1;
        endcase
    end

    // =====================================================
    // Next state of bus slave and registers
    always_comb
    begin
        logic [31:0] nw;
        logic [31:0] cur;
        nw = '0;
        cur = '0;
        r_d = r_q;
        r_d.start = 1'b0;
        r_d.abort = 1'b0;
        // Capture address and data
        if (s_axi_awvalid && !r_q.aw_held)
        begin
            r_d.aw_held = 1'b1;
            r_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_q.w_held)
        begin
            r_d.w_held = 1'b1;
            r_d.w_data = s_axi_wdata;
            r_d.w_strb = s_axi_wstrb;
        end
        // Responses drop once the master has taken them
        if (r_q.bvalid && s_axi_bready)
            r_d.bvalid = 1'b0;
        if (r_q.rvalid && s_axi_rready)
            r_d.rvalid = 1'b0;
        // Register write
        if (do_wr)
        begin
            r_d.aw_held = 1'b0;
            r_d.w_held = 1'b0;
            r_d.bvalid = 1'b1;
            r_d.bresp = RESP_OKAY;
            case ({r_q.aw_addr[7:2], 2'b00})
                CTRL_OFS:
                begin
                    nw = (ctrl_word & ~wmask) | (r_q.w_data & wmask);
                    r_d.reload = nw[RELOAD_BIT];
                    r_d.source_select = nw[SRC_BIT];
                    r_d.go = nw[GO_BIT];
                    // Rising go from idle starts; a repeated go while running is ignored
                    if (nw[GO_BIT] && !r_q.go && !busy)
                        r_d.start = 1'b1;
                    // Dropping go while busy stops the engine at its next safe point
                    if (!nw[GO_BIT] && busy)
                        r_d.abort = 1'b1;
                end
                DEST_OFS:
                begin
                    // Reserved upper bits are dropped on write
                    cur = {14'h0, r_q.dest_address};
                    nw = (cur & ~wmask) | (r_q.w_data & wmask);
                    r_d.dest_address = nw[ADDR_W-1:0];
                end
                LEN_OFS:
                begin
                    cur = {14'h0, r_q.byte_length};
                    nw = (cur & ~wmask) | (r_q.w_data & wmask);
                    r_d.byte_length = nw[ADDR_W-1:0];
                end
                IRQ_STAT_OFS:
                begin
                    // Write one to clear
                    r_d.irq_stat = r_q.irq_stat & ~(r_q.w_data[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
                end
                IRQ_MASK_OFS:
                begin
                    // A one lets its event reach the interrupt
                    nw = (r_q.w_data & wmask) | ({29'h0, r_q.irq_mask} & ~wmask);
                    r_d.irq_mask = nw[IRQ_W-1:0];
                end
                // Counter is read-only; the write is accepted and dropped
                PROG_OFS:
                    r_d.bresp = RESP_OKAY;
                default:
                    r_d.bresp = RESP_SLVERR;
            endcase
        end
        // Hardware clear follows the register write, so a finish that meets
        // a software write of go still leaves go low unless reload restarts the run
        if (eng_done || eng_err)
            r_d.go = 1'b0;
        // Reload restarts straight from the freshly loaded registers
        if (eng_done && r_q.reload)
        begin
            r_d.go = 1'b1;
            r_d.start = 1'b1;
        end
        // Events set after the clear so a same-cycle event survives
        if (eng_done)
            r_d.irq_stat[IRQ_DONE] = 1'b1;
        if (eng_err)
            r_d.irq_stat[IRQ_ERR] = 1'b1;
        if (r_q.abort)
            r_d.irq_stat[IRQ_ABORT] = 1'b1;
        // Register read
        if (do_rd)
        begin
            r_d.rvalid = 1'b1;
            r_d.rdata = rd_word;
            r_d.rresp = rd_bad ? RESP_SLVERR : RESP_OKAY;
        end
    end

    // =====================================================
    // Register the whole state
    // Reset clears it all: engine idle, go low, every ready high,
    // so the first bus request may come at the first edge after release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end
endmodule

// ==== sim/rx_dma_channel_asserts.sv ====
// Checker on the channel's FIFO and memory ports.
// Assumes one clock domain; bound into every channel instance.
`timescale 1ns/1ns
module rx_dma_channel_asserts
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Receive FIFOs
    input wire logic first_serial_rx_fifo_valid,
    input wire logic [7:0] first_serial_rx_fifo_data,
    input wire logic first_serial_rx_fifo_pop,
    input wire logic second_serial_rx_fifo_valid,
    input wire logic [7:0] second_serial_rx_fifo_data,
    input wire logic second_serial_rx_fifo_pop,
    // Memory port
    input wire logic mem_wr,
    input wire logic [17:0] mem_addr,
    input wire logic [7:0] mem_data,
    input wire logic mem_ready,
    input wire logic mem_err
);
    // Short aliases keep the properties readable
    wire p0 = first_serial_rx_fifo_pop;
    wire p1 = second_serial_rx_fifo_pop;
    wire ack = mem_ready || mem_err;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========
    // Fetch side
    property p_pop0_valid;
        p0 |-> first_serial_rx_fifo_valid;
    endproperty
    a_pop0_valid: assert property (p_pop0_valid) else $error("pop of empty fifo 0");
    property p_pop1_valid;
        p1 |-> second_serial_rx_fifo_valid;
    endproperty
    a_pop1_valid: assert property (p_pop1_valid) else $error("pop of empty fifo 1");
    property p_one_source;
        !(p0 && p1);
    endproperty
    a_one_source: assert property (p_one_source) else $error("both fifos popped");
    property p_data0;
        p0 |=> mem_wr && mem_data == $past(first_serial_rx_fifo_data);
    endproperty
    a_data0: assert property (p_data0) else $error("fifo 0 byte not written");
    property p_data1;
        p1 |=> mem_wr && mem_data == $past(second_serial_rx_fifo_data);
    endproperty
    a_data1: assert property (p_data1) else $error("fifo 1 byte not written");
    // ==========
    // Memory side
    property p_hold;
        mem_wr && !ack |=> mem_wr && $stable(mem_addr) && $stable(mem_data);
    endproperty
    a_hold: assert property (p_hold) else $error("write dropped early");
    property p_release;
        mem_wr && ack |=> !mem_wr;
    endproperty
    a_release: assert property (p_release) else $error("write repeated");
    // A failed write must stop the channel, not carry on
    property p_err_stop;
        mem_wr && mem_err |=> (!mem_wr && !p0 && !p1) [*3];
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("run after error");
endmodule
bind rx_dma_channel rx_dma_channel_asserts u_rx_dma_channel_asserts (.*);

// ==== sim/rx_dma_far.sv ====
// Model of the two receive FIFOs and the byte-wide data memory.
// Assumes the bench sets fill limits, memory stalls and faults.
`timescale 1ns/1ns
module rx_dma_far
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bench controls
    input wire logic slow,
    input wire logic err_en,
    input wire logic [7:0] lim0,
    input wire logic [7:0] lim1,
    // Receive FIFOs
    output logic first_serial_rx_fifo_valid,
    output logic [7:0] first_serial_rx_fifo_data,
    input wire logic first_serial_rx_fifo_pop,
    output logic second_serial_rx_fifo_valid,
    output logic [7:0] second_serial_rx_fifo_data,
    input wire logic second_serial_rx_fifo_pop,
    // Memory port
    input wire logic mem_wr,
    input wire logic [17:0] mem_addr,
    input wire logic [7:0] mem_data,
    output logic mem_ready,
    output logic mem_err
);
    logic [7:0] seq0;
    logic [7:0] seq1;
    logic [1:0] cyc;
    logic [7:0] mem [0:255];
    wire take = mem_wr && !mem_ready && !mem_err;
    // Empty FIFO shows inverted data, so a stale byte never matches
    always_comb
    begin
        first_serial_rx_fifo_valid = seq0 < lim0;
        second_serial_rx_fifo_valid = seq1 < lim1;
        first_serial_rx_fifo_data = {4'hA, seq0[3:0]} ^ {8{!first_serial_rx_fifo_valid}};
        second_serial_rx_fifo_data = {4'h5, seq1[3:0]} ^ {8{!second_serial_rx_fifo_valid}};
    end
    // Pop counts, one-cycle answers, slow mode answers every fourth cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq0 <= 8'h00;
            seq1 <= 8'h00;
            cyc <= 2'h0;
            mem_ready <= 1'h0;
            mem_err <= 1'h0;
        end
        else
        begin
            cyc <= cyc + 2'h1;
            seq0 <= seq0 + {7'h00, first_serial_rx_fifo_pop && first_serial_rx_fifo_valid};
            seq1 <= seq1 + {7'h00, second_serial_rx_fifo_pop && second_serial_rx_fifo_valid};
            mem_ready <= take && !err_en && (!slow || cyc == 2'h2);
            mem_err <= take && err_en;
            if (mem_wr && mem_ready)
                mem[mem_addr[7:0]] <= mem_data;
        end
    end
endmodule

// ==== sim/rx_dma_channel_bench.sv ====
// Self-checking bench for the receive DMA channel.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ns
module rx_dma_channel_bench;
    import rx_dma_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic first_serial_rx_fifo_valid, first_serial_rx_fifo_pop;
    logic second_serial_rx_fifo_valid, second_serial_rx_fifo_pop;
    logic [7:0] first_serial_rx_fifo_data, second_serial_rx_fifo_data, mem_data;
    logic mem_wr, mem_ready, mem_err, irq;
    logic [17:0] mem_addr;
    logic slow = 1'h0, err_en = 1'h0;
    logic [7:0] lim0 = 8'h00, lim1 = 8'h00;
    logic [31:0] rd_q;
    int n_mismatch = 0;
    int num_checks = 0;
    rx_dma_channel u_rx_dma_channel (.*);
    rx_dma_far u_rx_dma_far (.*);
    always #4 aclk = ~aclk;
    // ==========
    // Reporting
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that runs out ends the run at once
    task automatic lose();
        check(32'h1, 32'h0);
        close_out();
    endtask
    // ==========
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50 && !s_axi_bvalid; n++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        if (n == 50)
            lose();
        check({30'h0, s_axi_bresp}, {30'h0, e});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50 && !s_axi_rvalid; n++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        if (n == 50)
            lose();
        rd_q = {s_axi_rresp == RESP_SLVERR, 31'h0} | s_axi_rdata;
        check(rd_q, e);
    endtask
    task automatic wait_irq();
        int n;
        for (n = 0; n < 300 && irq !== 1'h1; n++)
            @(posedge aclk);
        if (n == 300)
            lose();
    endtask
    // Waits for pop totals, then lets the last write land
    task automatic wait_seq(input logic [7:0] t0, input logic [7:0] t1);
        int n;
        for (n = 0; n < 300 && !(u_rx_dma_far.seq0 == t0 && u_rx_dma_far.seq1 == t1); n++)
            @(posedge aclk);
        if (n == 300)
            lose();
        repeat (6) @(posedge aclk);
    endtask
    task automatic mem_is(input logic [7:0] a, input logic [7:0] e);
        check({24'h0, u_rx_dma_far.mem[a]}, {24'h0, e});
    endtask
    // ==========
    // Scenarios
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 6; i++)
            rd(CTRL_OFS + 8'(4 * i), 32'h0);
        wr(DEST_OFS, 32'hFFFF_FFFF, RESP_OKAY);
        rd(DEST_OFS, 32'h0003_FFFF);
        wr(PROG_OFS, 32'h0000_0055, RESP_OKAY);
        rd(PROG_OFS, 32'h0);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h8000_0000);
        wr(IRQ_MASK_OFS, 32'h7, RESP_OKAY);
        wr(DEST_OFS, 32'h10, RESP_OKAY);
        wr(LEN_OFS, 32'h4, RESP_OKAY);
        lim0 <= 8'h02;
        wr(CTRL_OFS, 32'h1, RESP_OKAY);
        wait_seq(8'h02, 8'h00);
        rd(PROG_OFS, 32'h2);
        wr(DEST_OFS, 32'h50, RESP_OKAY);
        lim0 <= 8'h04;
        wait_irq();
        rd(IRQ_STAT_OFS, 32'h1);
        rd(CTRL_OFS, 32'h0);
        rd(PROG_OFS, 32'h0);
        for (int i = 0; i < 4; i++)
            mem_is(8'h10 + 8'(i), {4'hA, 4'(i)});
        check({24'h0, u_rx_dma_far.seq0}, 32'h4);
        wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        wr(IRQ_MASK_OFS, 32'h7, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        wr(IRQ_STAT_OFS, 32'h1, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        // Second source under a stalling memory
        slow <= 1'h1;
        lim1 <= 8'h03;
        wr(DEST_OFS, 32'h20, RESP_OKAY);
        wr(LEN_OFS, 32'h3, RESP_OKAY);
        wr(CTRL_OFS, 32'h11, RESP_OKAY);
        wait_irq();
        slow <= 1'h0;
        wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
        for (int i = 0; i < 3; i++)
            mem_is(8'h20 + 8'(i), {4'h5, 4'(i)});
        check({24'h0, u_rx_dma_far.seq0}, 32'h4);
        // Abort while waiting on an empty FIFO
        lim1 <= 8'h04;
        wr(LEN_OFS, 32'h5, RESP_OKAY);
        wr(CTRL_OFS, 32'h11, RESP_OKAY);
        wait_seq(8'h04, 8'h04);
        wr(CTRL_OFS, 32'h10, RESP_OKAY);
        rd(IRQ_STAT_OFS, 32'h2);
        rd(PROG_OFS, 32'h1);
        wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
        // Memory error ends the transfer
        err_en <= 1'h1;
        lim0 <= 8'h05;
        wr(CTRL_OFS, 32'h1, RESP_OKAY);
        wait_irq();
        rd(IRQ_STAT_OFS, 32'h4);
        rd(CTRL_OFS, 32'h0);
        err_en <= 1'h0;
        wr(IRQ_STAT_OFS, 32'h7, RESP_OKAY);
        // Reload runs twice into the same place
        lim0 <= 8'h09;
        wr(DEST_OFS, 32'h30, RESP_OKAY);
        wr(LEN_OFS, 32'h2, RESP_OKAY);
        wr(CTRL_OFS, 32'h3, RESP_OKAY);
        wait_seq(8'h09, 8'h04);
        rd(CTRL_OFS, 32'h3);
        wr(CTRL_OFS, 32'h0, RESP_OKAY);
        rd(IRQ_STAT_OFS, 32'h3);
        mem_is(8'h30, 8'hA7);
        mem_is(8'h31, 8'hA8);
        close_out();
    end
endmodule
